// *** src/program_rom_page_mapper.sv ***
// program counter to paged program memory mapper with stack and nmi edge
// Function
// - the 12-bit program counter drives every program memory access
// - counter bit 11 set always maps to static page 1
// - bit 11 clear: page-select bits pick page 0 to 3
// - page 1 via either half reaches the same physical memory
// - page-select is a write-only register at data address CAh
// - interrupts and calls leave the page-select register untouched
// - page-select holds no defined value after reset
// - only bits 1:0 of page-select are kept, bits 7:2 ignored
// - vectors fetched from static page at FF0-FF7, FFC-FFD, FFE-FFF
// - low reset restarts the core, which resumes through the reset vector
// - programming pin high during reset enters programming mode
// - falling edge of the nmi input raises a non-maskable request
// - six-level return stack shared by calls and interrupts
// - every stack level holds a full 12-bit counter value
`timescale 1ns/1ps
module program_rom_page_mapper
	import rom_pager_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// core fetch side
	input wire logic [11:0] program_counter,
	input wire logic fetch_req,
	// core data-space write port
	input wire data_write_t data_wr,
	// return stack
	input wire stack_req_t stack_req,
	// pins
	input wire logic nmi_n,
	input wire logic prog_entry,
	// program memory side
	output logic [12:0] phys_addr,
	output logic phys_rd,
	// status to core
	output logic [1:0] page_select_bits,
	output logic nmi_pending,
	output logic [11:0] stack_top,
	output logic stack_full,
	output logic stack_empty,
	output logic vector_fetch,
	output logic restart_pulse,
	output logic program_mode
);

	function automatic logic [1:0] page_of(input logic [11:0] pc,
		input logic [1:0] sel);
		// upper half always lands in the static page
		page_of = pc[STATIC_BIT] ? STATIC_PAGE : sel;
	endfunction : page_of

	function automatic logic is_vector(input logic [11:0] pc);
		is_vector = (pc[11:3] == VEC_IRQ_BASE[11:3]) ||
			(pc[11:1] == VEC_NMI[11:1]) ||
			(pc[11:1] == VEC_RESET[11:1]);
	endfunction : is_vector

	// page-select register
	logic [1:0] next_page_select_bits;
	logic page_wr;

	assign page_wr = data_wr.we && (data_wr.addr == PAGE_SELECT_ADDR);

	always_comb begin
		next_page_select_bits = page_select_bits;
		if (page_wr) begin
			// upper bits of the byte are dropped
			next_page_select_bits =
				data_wr.wdata[PAGE_BITS_LSB +: PAGE_BITS_W];
		end
	end

	// not in reset: contents are unspecified until software writes it; a
	// stack push or nmi never touches it
	always_ff @(posedge ref_clk) begin
		page_select_bits <= next_page_select_bits;
	end

	// remembers a page write since reset, so the checks below never judge
	// the undefined contents that software has not yet written
	logic page_known, next_page_known;

	always_comb begin
		next_page_known = page_known | page_wr;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			page_known <= 1'b0;
		end else begin
			page_known <= next_page_known;
		end
	end

	// address mapping, registered so outputs come from flops
	logic [12:0] next_phys_addr;
	logic next_phys_rd;
	logic next_vector_fetch;

	always_comb begin
		next_phys_addr = {page_of(program_counter, page_select_bits),
			program_counter[10:0]};
		next_phys_rd = fetch_req;
		next_vector_fetch = fetch_req && is_vector(program_counter);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			phys_addr <= {PAGE_RESET_FILL, VEC_RESET[10:0]};
			phys_rd <= 1'b0;
			vector_fetch <= 1'b0;
		end else begin
			phys_addr <= next_phys_addr;
			phys_rd <= next_phys_rd;
			vector_fetch <= next_vector_fetch;
		end
	end

	// reset and programming mode entry
	mode_t mode, next_mode;
	logic prog_seen, next_prog_seen;
	logic next_restart_pulse;
	logic next_program_mode;

	always_comb begin
		next_mode = mode;
		next_prog_seen = prog_seen | prog_entry;
		next_restart_pulse = 1'b0;
		next_program_mode = program_mode;
		unique case (mode)
			ST_RESET: begin
				if (prog_seen) begin
					next_mode = ST_PROGRAM;
					next_program_mode = 1'b1;
				end else begin
					next_mode = ST_RUN;
					next_restart_pulse = 1'b1;
				end
			end
			ST_RUN: begin
			end
			ST_PROGRAM: begin
			end
			default: begin
				next_mode = ST_RESET;
			end
		endcase
	end

	// the strap is sampled by the clock while reset is held
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			mode <= ST_RESET;
			prog_seen <= prog_entry;
			restart_pulse <= 1'b0;
			program_mode <= 1'b0;
		end else begin
			mode <= next_mode;
			prog_seen <= next_prog_seen & (mode == ST_RESET);
			restart_pulse <= next_restart_pulse;
			program_mode <= next_program_mode;
		end
	end

	// nmi falling edge detect; input is taken as synchronous
	logic nmi_prev, next_nmi_prev;
	logic next_nmi_pending;
	logic nmi_fall;
	logic nmi_ack;

	// the core acknowledges by fetching the nmi vector
	assign nmi_ack = next_vector_fetch && (program_counter[11:1] ==
		VEC_NMI[11:1]);
	assign nmi_fall = nmi_prev && !nmi_n;

	always_comb begin
		next_nmi_prev = nmi_n;
		next_nmi_pending = nmi_pending;
		if (nmi_ack) begin
			next_nmi_pending = 1'b0;
		end
		// a new edge in the acknowledge cycle is kept
		if (nmi_fall) begin
			next_nmi_pending = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			nmi_prev <= 1'b1;
			nmi_pending <= 1'b0;
		end else begin
			nmi_prev <= next_nmi_prev;
			nmi_pending <= next_nmi_pending;
		end
	end

	// six-level return stack
	logic [11:0] stack_mem [STACK_DEPTH];
	logic [11:0] next_stack_mem [STACK_DEPTH];
	logic [2:0] stack_ptr, next_stack_ptr;
	logic [11:0] next_stack_top;
	logic do_push, do_pop;

	assign do_push = stack_req.push && !stack_req.pop &&
		(stack_ptr != 3'(STACK_DEPTH));
	assign do_pop = stack_req.pop && !stack_req.push &&
		(stack_ptr != STACK_PTR_RESET);

	always_comb begin
		next_stack_ptr = stack_ptr;
		for (int i = 0; i < STACK_DEPTH; i++) begin
			next_stack_mem[i] = stack_mem[i];
		end
		// overflow discards the push, a limitation software must respect
		if (do_push) begin
			next_stack_mem[stack_ptr] = stack_req.ret_addr;
			next_stack_ptr = stack_ptr + 3'h1;
		end else if (do_pop) begin
			next_stack_ptr = stack_ptr - 3'h1;
		end
		next_stack_top = (next_stack_ptr == STACK_PTR_RESET) ? 12'h000 :
			next_stack_mem[next_stack_ptr - 3'h1];
	end

	genvar g;
	generate
		for (g = 0; g < STACK_DEPTH; g++) begin : g_level
			always_ff @(posedge ref_clk) begin
				stack_mem[g] <= next_stack_mem[g];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			stack_ptr <= STACK_PTR_RESET;
			stack_top <= 12'h000;
			stack_full <= 1'b0;
			stack_empty <= 1'b1;
		end else begin
			stack_ptr <= next_stack_ptr;
			stack_top <= next_stack_top;
			stack_full <= (next_stack_ptr == 3'(STACK_DEPTH));
			stack_empty <= (next_stack_ptr == STACK_PTR_RESET);
		end
	end

	// checks
	chk_upper_static: assert property (@(posedge ref_clk)
		disable iff (!reset_n) program_counter[11] |=>
		phys_addr[12:11] == STATIC_PAGE)
		else $error("upper half not mapped to static page");
	chk_lower_sel: assert property (@(posedge ref_clk)
		disable iff (!reset_n) page_known && !program_counter[11] |=>
		phys_addr[12:11] == $past(page_select_bits))
		else $error("lower half page mismatch");
	chk_offset_kept: assert property (@(posedge ref_clk)
		disable iff (!reset_n) 1'b1 |=>
		phys_addr[10:0] == $past(program_counter[10:0]))
		else $error("offset bits not carried");
	chk_page_write: assert property (@(posedge ref_clk)
		disable iff (!reset_n) page_wr |=>
		page_select_bits == $past(data_wr.wdata[1:0]))
		else $error("page-select write lost");
	chk_page_hold: assert property (@(posedge ref_clk)
		disable iff (!reset_n) page_known && !page_wr |=>
		$stable(page_select_bits))
		else $error("page-select changed without write");
	chk_nmi_edge: assert property (@(posedge ref_clk)
		disable iff (!reset_n) $fell(nmi_n) |=>
		nmi_pending)
		else $error("nmi edge missed");
	chk_nmi_clear: assert property (@(posedge ref_clk)
		disable iff (!reset_n) nmi_ack && !nmi_fall |=>
		!nmi_pending)
		else $error("nmi request not cleared by vector fetch");
	chk_stack_depth: assert property (@(posedge ref_clk)
		disable iff (!reset_n)
		stack_ptr <= 3'(STACK_DEPTH))
		else $error("stack pointer beyond six");
	chk_push_refused: assert property (@(posedge ref_clk)
		disable iff (!reset_n) stack_req.push &&
		stack_ptr == 3'(STACK_DEPTH) |=> stack_ptr == 3'(STACK_DEPTH))
		else $error("push accepted on a full stack");
	chk_pop_level: assert property (@(posedge ref_clk)
		disable iff (!reset_n) do_pop |=>
		stack_ptr == $past(stack_ptr) - 3'h1)
		else $error("pop did not drop one level");
	chk_push_top: assert property (@(posedge ref_clk)
		disable iff (!reset_n) do_push |=>
		stack_top == $past(stack_req.ret_addr))
		else $error("pushed address not on top");
	chk_read_strobe: assert property (@(posedge ref_clk)
		disable iff (!reset_n) fetch_req |=>
		phys_rd)
		else $error("fetch not passed to program memory");
	chk_reset_vector: assert property (@(posedge ref_clk)
		disable iff (!reset_n) fetch_req && program_counter == VEC_RESET
		|=> vector_fetch && phys_addr == {STATIC_PAGE, VEC_RESET[10:0]})
		else $error("reset vector not fetched from static page");
	chk_restart_once: assert property (@(posedge ref_clk)
		$rose(reset_n) && !prog_seen |=>
		restart_pulse ##1 !restart_pulse)
		else $error("restart pulse wrong");
	chk_prog_entry: assert property (@(posedge ref_clk)
		!reset_n && prog_entry ##1 reset_n |=>
		program_mode)
		else $error("programming mode not entered");

endmodule : program_rom_page_mapper

// *** src/rom_pager_pkg.sv ***
// shared constants and carriers for the program memory page mapper
package rom_pager_pkg;
	localparam int PC_W = 12;
	localparam int PHYS_W = 13;
	localparam int DATA_ADDR_W = 8;
	localparam logic [7:0] PAGE_SELECT_ADDR = 8'hCA;
	localparam int PAGE_BITS_LSB = 0;
	localparam int PAGE_BITS_W = 2;
	localparam int STATIC_BIT = 11;
	localparam logic [1:0] STATIC_PAGE = 2'h1;
	localparam int STACK_DEPTH = 6;
	localparam logic [11:0] VEC_IRQ_BASE = 12'hFF0;
	localparam logic [11:0] VEC_NMI = 12'hFFC;
	localparam logic [11:0] VEC_RESET = 12'hFFE;
	localparam logic [2:0] STACK_PTR_RESET = 3'h0;
	localparam logic [1:0] PAGE_RESET_FILL = 2'h0;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} data_write_t;

	typedef struct packed {
		logic push;
		logic pop;
		logic [11:0] ret_addr;
	} stack_req_t;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_RUN = 2'b01,
		ST_PROGRAM = 2'b10
	} mode_t;
endpackage : rom_pager_pkg

// *** verif/fetch_core_model.sv ***
// core-side model: drives fetch addresses and data-space byte writes
`timescale 1ns/1ps
module fetch_core_model
	import rom_pager_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// core outputs toward the mapper
	output logic [11:0] program_counter,
	output logic fetch_req,
	output data_write_t data_wr
);
	initial begin
		program_counter = 12'h000;
		fetch_req = 1'b0;
		data_wr = '0;
	end

	// one fetch strobe; the address keeps its level afterwards
	task fetch(input logic [11:0] pc);
		@(posedge ref_clk);
		#5;
		program_counter = pc;
		fetch_req = 1'b1;
		@(posedge ref_clk);
		#5;
		fetch_req = 1'b0;
	endtask : fetch

	// whole-byte stores only, never a read-modify-write of the page byte
	task write_byte(input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk);
		#5;
		data_wr = '{1'b1, addr, data};
		@(posedge ref_clk);
		#5;
		data_wr = '{1'b0, ~addr, ~data};
	endtask : write_byte
endmodule : fetch_core_model

// *** verif/test_program_rom_page_mapper.sv ***
// self-checking bench for the program memory page mapper
`timescale 1ns/1ps
module test_program_rom_page_mapper;
	import rom_pager_pkg::*;
	logic ref_clk = 0;
	logic reset_n = 0;
	logic nmi_n = 1;
	logic prog_entry = 0;
	stack_req_t stack_req = '0;
	logic [11:0] program_counter;
	logic fetch_req;
	data_write_t data_wr;
	logic [12:0] phys_addr;
	logic [1:0] page_select_bits;
	logic [11:0] stack_top;
	logic phys_rd, nmi_pending, stack_full, stack_empty, vector_fetch;
	logic restart_pulse, program_mode;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	program_rom_page_mapper u_program_rom_page_mapper(.ref_clk(ref_clk),
		.reset_n(reset_n), .program_counter(program_counter),
		.fetch_req(fetch_req), .data_wr(data_wr), .stack_req(stack_req),
		.nmi_n(nmi_n), .prog_entry(prog_entry), .phys_addr(phys_addr),
		.phys_rd(phys_rd), .page_select_bits(page_select_bits),
		.nmi_pending(nmi_pending), .stack_top(stack_top),
		.stack_full(stack_full), .stack_empty(stack_empty),
		.vector_fetch(vector_fetch), .restart_pulse(restart_pulse),
		.program_mode(program_mode));
	fetch_core_model u_fetch_core_model(.ref_clk(ref_clk),
		.program_counter(program_counter), .fetch_req(fetch_req),
		.data_wr(data_wr));

	initial forever #25 ref_clk = ~ref_clk;

	task conclude;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end

	task chk(input string what, input logic [12:0] exp,
		input logic [12:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task step;
		@(posedge ref_clk);
		#5;
	endtask : step

	task do_reset(input logic strap);
		reset_n = 0;
		prog_entry = strap;
		repeat (16) step();
		reset_n = 1;
		prog_entry = 0;
		step();
		chk("restart", !strap, restart_pulse);
		chk("prog mode", strap, program_mode);
		chk("empty", 1, stack_empty);
		step();
		chk("restart end", 0, restart_pulse);
	endtask : do_reset

	task test_pages;
		for (int p = 0; p < 4; p++) begin
			u_fetch_core_model.fetch(12'h923);
			chk("upper", {STATIC_PAGE, 11'h123}, phys_addr);
			u_fetch_core_model.write_byte(PAGE_SELECT_ADDR,
				{6'h3F, p[1:0]});
			chk("page bits", p, page_select_bits);
			u_fetch_core_model.fetch(12'h123);
			chk("lower", {p[1:0], 11'h123}, phys_addr);
			chk("read", 1, phys_rd);
		end
		u_fetch_core_model.write_byte(8'hCB, 8'h00);
		chk("other addr", 3, page_select_bits);
	endtask : test_pages

	task test_vectors;
		logic [11:0] pcs [4] = '{12'hFF7, 12'hFF8, 12'hFFD, VEC_RESET};
		for (int i = 0; i < 4; i++) begin
			u_fetch_core_model.fetch(pcs[i]);
			chk("vector", i != 1, vector_fetch);
		end
	endtask : test_vectors

	task push_pop(input logic push, input logic [11:0] ret);
		step();
		stack_req = '{push, !push, ret};
		step();
		stack_req = '0;
	endtask : push_pop

	task test_stack;
		for (int i = 0; i < 7; i++)
			push_pop(1, 12'hF00 + 12'(i));
		chk("full", 1, stack_full);
		chk("top", 12'hF05, stack_top);
		push_pop(0, 12'h000);
		chk("pop", 12'hF04, stack_top);
		// a store to data address 90h only, not the page register, must leave the page byte at 3
		u_fetch_core_model.write_byte(8'h90, 8'h01);
		chk("page kept", 3, page_select_bits);
	endtask : test_stack

	task test_nmi;
		chk("nmi idle", 0, nmi_pending);
		nmi_n = 0;
		step();
		chk("nmi set", 1, nmi_pending);
		u_fetch_core_model.fetch(VEC_NMI);
		step();
		chk("nmi low level", 0, nmi_pending);
		nmi_n = 1;
	endtask : test_nmi

	initial begin
		do_reset(0);
		test_pages();
		test_vectors();
		test_stack();
		test_nmi();
		do_reset(1);
		conclude();
	end
endmodule : test_program_rom_page_mapper
